/* dubp_pkg.sv */
`default_nettype none
package dubp_pkg;
  // ==========================================================
  // widths and channels
  localparam int DUBP_DATA_W   = 8;
  localparam int DUBP_ADDR_W   = 3;
  localparam int DUBP_ERR_W    = 3;
  localparam int DUBP_NUM_CHAN = 2;
  localparam int DUBP_FIFO_DEP = 16;
  localparam int DUBP_SYNC_W   = 15;

  // ==========================================================
  // register offsets
  localparam logic [2:0] DUBP_REG_DATA     = 3'h0;
  localparam logic [2:0] DUBP_REG_IRQ_EN   = 3'h1;
  localparam logic [2:0] DUBP_REG_FIFO_CTL = 3'h2;
  localparam logic [2:0] DUBP_REG_MODEM    = 3'h4;
  localparam logic [2:0] DUBP_REG_LINE     = 3'h5;
  localparam logic [2:0] DUBP_REG_RX_LVL   = 3'h6;
  localparam logic [2:0] DUBP_REG_SCRATCH  = 3'h7;

  // ==========================================================
  // field positions and reset values
  localparam int DUBP_MCR_IRQ_BIT  = 3;
  localparam int DUBP_FCR_RX_CLR   = 1;
  localparam int DUBP_FCR_TX_CLR   = 2;
  localparam int DUBP_FCR_TRIG_LSB = 6;
  localparam int DUBP_LSR_RX_DATA  = 0;
  localparam int DUBP_LSR_ERR_LSB  = 1;
  localparam int DUBP_LSR_TX_ROOM  = 5;
  localparam int DUBP_LSR_TX_EMPTY = 6;
  localparam logic [7:0] DUBP_MCR_RST = 8'h00;
  localparam logic [1:0] DUBP_IER_RST = 2'h0;
  localparam logic [1:0] DUBP_TRIG_RST = 2'h0;
  // strobes and selects idle high
  localparam logic [14:0] DUBP_SYNC_RST = 15'h7800;
  localparam logic [4:0] DUBP_TRIG_LVL [4] = '{5'h01, 5'h04, 5'h08, 5'h0E};

  // ==========================================================
  // host cycle timing
  localparam int DUBP_CLK_NS    = 10;
  localparam int DUBP_SETUP_NS  = 40;
  localparam int DUBP_STROBE_NS = 80;
  localparam int DUBP_HOLD_NS   = 50;
  localparam int DUBP_SETUP_CYC  = (DUBP_SETUP_NS + DUBP_CLK_NS - 1) / DUBP_CLK_NS;
  localparam int DUBP_STROBE_CYC = (DUBP_STROBE_NS + DUBP_CLK_NS - 1) / DUBP_CLK_NS;
  localparam int DUBP_HOLD_CYC   = (DUBP_HOLD_NS + DUBP_CLK_NS - 1) / DUBP_CLK_NS;
endpackage : dubp_pkg
`default_nettype wire

/* dubp_bus_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface dubp_bus_if ();
  logic [2:0] reg_addr;
  logic [7:0] host_data;
  logic       host_data_oe;
  logic [7:0] dev_data;
  logic       dev_data_oe;
  logic [7:0] bus_data;
  logic       read_strobe_n;
  logic       write_strobe_n;
  logic       chan_a_select_n;
  logic       chan_b_select_n;
  logic       chan_a_irq;
  logic       chan_a_irq_oe;
  logic       chan_b_irq;
  logic       chan_b_irq_oe;
  logic       chan_a_gp_out2_n;
  logic       chan_b_gp_out2_n;
  logic       chan_a_tx_ready_n;
  logic       chan_b_tx_ready_n;
  logic       chan_a_rx_ready_n;
  logic       chan_b_rx_ready_n;

  // undriven bus floats high, as with a pull-up
  assign bus_data = host_data_oe ? host_data : (dev_data_oe ? dev_data : 8'hFF);

  modport device_mp (
    input  reg_addr, bus_data, read_strobe_n, write_strobe_n,
    input  chan_a_select_n, chan_b_select_n,
    output dev_data, dev_data_oe, chan_a_irq, chan_a_irq_oe, chan_b_irq, chan_b_irq_oe,
    output chan_a_gp_out2_n, chan_b_gp_out2_n, chan_a_tx_ready_n, chan_b_tx_ready_n,
    output chan_a_rx_ready_n, chan_b_rx_ready_n
  );
  modport host_mp (
    output reg_addr, host_data, host_data_oe, read_strobe_n, write_strobe_n,
    output chan_a_select_n, chan_b_select_n,
    input  bus_data, chan_a_irq, chan_a_irq_oe, chan_b_irq, chan_b_irq_oe,
    input  chan_a_gp_out2_n, chan_b_gp_out2_n, chan_a_tx_ready_n, chan_b_tx_ready_n,
    input  chan_a_rx_ready_n, chan_b_rx_ready_n
  );
endinterface : dubp_bus_if
`default_nettype wire

/* dubp_fifo.sv */
`timescale 1ns/100ps
`default_nettype none
module dubp_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 16,
  parameter int PW    = $clog2(DEPTH)
) (
  // clock and reset
  input  wire logic          sys_clk,
  input  wire logic          srst,
  input  wire logic          clr,
  // fill side
  input  wire logic          push,
  input  wire logic [W-1:0]  push_data,
  // drain side
  input  wire logic          pop,
  output logic      [W-1:0]  head,
  output logic      [PW:0]   count,
  output logic               full,
  output logic               empty
);
  localparam logic [PW:0] FULL_CNT = (PW+1)'(DEPTH);
  logic [W-1:0]  mem [DEPTH];
  logic [PW-1:0] wp_q;
  logic [PW-1:0] rp_q;
  logic [PW:0]   cnt_q;
  logic          do_push;
  logic          do_pop;

  // overflow drops the byte, underflow is a no-op
  assign do_push = push && (cnt_q != FULL_CNT);
  assign do_pop  = pop && (cnt_q != '0);
  assign head    = mem[rp_q];
  assign count   = cnt_q;
  assign full    = (cnt_q == FULL_CNT);
  assign empty   = (cnt_q == '0);

  always_ff @(posedge sys_clk) begin
    if (do_push) begin
      mem[wp_q] <= push_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst || clr) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (do_push) begin
        wp_q <= wp_q + 1'b1;
      end
      if (do_pop) begin
        rp_q <= rp_q + 1'b1;
      end
      if (do_push && !do_pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (do_pop && !do_push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule : dubp_fifo
`default_nettype wire

/* dubp_device.sv */
`timescale 1ns/100ps
`default_nettype none
module dubp_device #(
  parameter int FIFO_DEPTH = dubp_pkg::DUBP_FIFO_DEP
) (
  // clock and reset
  input  wire logic                                  sys_clk,
  input  wire logic                                  srst,
  // host pins
  dubp_bus_if.device_mp                              bus,
  // transmit stream to serial engines
  output logic [dubp_pkg::DUBP_NUM_CHAN-1:0]         tx_valid,
  output logic [dubp_pkg::DUBP_NUM_CHAN-1:0][7:0]    tx_data,
  input  wire logic [dubp_pkg::DUBP_NUM_CHAN-1:0]    tx_ready,
  // receive stream from serial engines
  input  wire logic [dubp_pkg::DUBP_NUM_CHAN-1:0]      rx_valid,
  input  wire logic [dubp_pkg::DUBP_NUM_CHAN-1:0][7:0] rx_data,
  input  wire logic [dubp_pkg::DUBP_NUM_CHAN-1:0][2:0] rx_err
);
  import dubp_pkg::*;

  localparam int PW = $clog2(FIFO_DEPTH);
  localparam int RW = DUBP_DATA_W + DUBP_ERR_W;

  // ==========================================================
  // pin synchronisers
  logic [DUBP_SYNC_W-1:0] raw;
  logic [DUBP_SYNC_W-1:0] s1_q;
  logic [DUBP_SYNC_W-1:0] s2_q;
  logic [DUBP_SYNC_W-1:0] s3_q;
  logic [DUBP_SYNC_W-1:0] filt_q;
  logic [DUBP_SYNC_W-1:0] upd;

  assign raw = {bus.read_strobe_n, bus.write_strobe_n, bus.chan_a_select_n,
                bus.chan_b_select_n, bus.reg_addr, bus.bus_data};

  for (genvar i = 0; i < DUBP_SYNC_W; i++) begin : sync_g
    // level counts only once stages two and three agree
    assign upd[i] = (s2_q[i] == s3_q[i]) && (s3_q[i] != filt_q[i]);
    always_ff @(posedge sys_clk) begin
      if (srst) begin
        s1_q[i]   <= DUBP_SYNC_RST[i];
        s2_q[i]   <= DUBP_SYNC_RST[i];
        s3_q[i]   <= DUBP_SYNC_RST[i];
        filt_q[i] <= DUBP_SYNC_RST[i];
      end else begin
        s1_q[i] <= raw[i];
        s2_q[i] <= s1_q[i];
        s3_q[i] <= s2_q[i];
        if (upd[i]) begin
          filt_q[i] <= s3_q[i];
        end
      end
    end
  end

  // ==========================================================
  // strobe decode
  logic       sel_a;
  logic       sel_b;
  logic       any_sel;
  logic       acc_chan;
  logic [2:0] f_addr;
  logic [7:0] f_data;
  logic       rd_fall;
  logic       rd_rise;
  logic       wr_fall;
  logic       wr_rise;
  logic       rd_go;
  logic       wr_go;
  logic       wr_act_q;
  logic       wr_chan_q;

  assign sel_a    = !filt_q[12];
  assign sel_b    = !filt_q[11];
  assign any_sel  = sel_a || sel_b;
  assign acc_chan = !sel_a;
  assign f_addr   = filt_q[10:8];
  assign f_data   = filt_q[7:0];
  assign rd_fall  = upd[14] && !s3_q[14];
  assign rd_rise  = upd[14] && s3_q[14];
  assign wr_fall  = upd[13] && !s3_q[13];
  assign wr_rise  = upd[13] && s3_q[13];
  assign rd_go    = rd_fall && any_sel;
  assign wr_go    = wr_rise && wr_act_q;

  // write opens on the fall, commits on the rise
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wr_act_q  <= 1'b0;
      wr_chan_q <= 1'b0;
    end else if (wr_fall) begin
      wr_act_q  <= any_sel;
      wr_chan_q <= acc_chan;
    end else if (wr_rise) begin
      wr_act_q <= 1'b0;
    end
  end

  // ==========================================================
  // read data driver
  logic [7:0] rd_byte [DUBP_NUM_CHAN];
  logic [7:0] dev_data_q;
  logic       dev_oe_q;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      dev_data_q <= 8'h00;
      dev_oe_q   <= 1'b0;
    end else if (rd_go) begin
      dev_data_q <= rd_byte[acc_chan];
      dev_oe_q   <= 1'b1;
    end else if (rd_rise) begin
      dev_oe_q <= 1'b0;
    end
  end

  assign bus.dev_data    = dev_data_q;
  assign bus.dev_data_oe = dev_oe_q;

  // ==========================================================
  // channels
  for (genvar c = 0; c < DUBP_NUM_CHAN; c++) begin : ch_g
    logic [1:0]    ier_q;
    logic [1:0]    trig_q;
    logic [7:0]    mcr_q;
    logic [7:0]    scr_q;
    logic          txv_q;
    logic [7:0]    txd_q;
    logic          irq_q;
    logic          irq_oe_q;
    logic          gp_n_q;
    logic          txr_n_q;
    logic          rxr_n_q;
    logic          wr_hit;
    logic          rd_hit;
    logic          tx_push;
    logic          tx_pop;
    logic          tx_clr;
    logic          rx_clr;
    logic          rx_pop;
    logic [7:0]    tx_head;
    logic [PW:0]   tx_cnt;
    logic          tx_full;
    logic          tx_empty;
    logic [RW-1:0] rx_head;
    logic [PW:0]   rx_cnt;
    logic          rx_full;
    logic          rx_empty;
    logic          rx_trig;
    logic [7:0]    rb;

    assign wr_hit  = wr_go && (wr_chan_q == 1'(c));
    assign rd_hit  = rd_go && (acc_chan == 1'(c));
    assign tx_push = wr_hit && (f_addr == DUBP_REG_DATA);
    assign rx_pop  = rd_hit && (f_addr == DUBP_REG_DATA);
    assign tx_clr  = wr_hit && (f_addr == DUBP_REG_FIFO_CTL) && f_data[DUBP_FCR_TX_CLR];
    assign rx_clr  = wr_hit && (f_addr == DUBP_REG_FIFO_CTL) && f_data[DUBP_FCR_RX_CLR];
    // output stage keeps the stream pin on a flop
    assign tx_pop  = !tx_empty && (!txv_q || tx_ready[c]);
    assign rx_trig = int'(rx_cnt) >= int'(DUBP_TRIG_LVL[trig_q]);

    dubp_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) tx_fifo (
      .sys_clk   (sys_clk),
      .srst      (srst),
      .clr       (tx_clr),
      .push      (tx_push),
      .push_data (f_data),
      .pop       (tx_pop),
      .head      (tx_head),
      .count     (tx_cnt),
      .full      (tx_full),
      .empty     (tx_empty)
    );

    dubp_fifo #(.W(RW), .DEPTH(FIFO_DEPTH)) rx_fifo (
      .sys_clk   (sys_clk),
      .srst      (srst),
      .clr       (rx_clr),
      .push      (rx_valid[c]),
      .push_data ({rx_err[c], rx_data[c]}),
      .pop       (rx_pop),
      .head      (rx_head),
      .count     (rx_cnt),
      .full      (rx_full),
      .empty     (rx_empty)
    );

    // control registers
    always_ff @(posedge sys_clk) begin
      if (srst) begin
        ier_q  <= DUBP_IER_RST;
        trig_q <= DUBP_TRIG_RST;
        mcr_q  <= DUBP_MCR_RST;
        scr_q  <= 8'h00;
      end else if (wr_hit) begin
        case (f_addr)
          DUBP_REG_IRQ_EN:   ier_q  <= f_data[1:0];
          DUBP_REG_FIFO_CTL: trig_q <= f_data[DUBP_FCR_TRIG_LSB +: 2];
          DUBP_REG_MODEM:    mcr_q  <= f_data;
          DUBP_REG_SCRATCH:  scr_q  <= f_data;
          default: ;
        endcase
      end
    end

    always_ff @(posedge sys_clk) begin
      if (srst) begin
        txv_q <= 1'b0;
        txd_q <= 8'h00;
      end else if (tx_pop) begin
        txv_q <= 1'b1;
        txd_q <= tx_head;
      end else if (tx_ready[c]) begin
        txv_q <= 1'b0;
      end
    end

    // status pins
    always_ff @(posedge sys_clk) begin
      if (srst) begin
        irq_q    <= 1'b0;
        irq_oe_q <= 1'b0;
        gp_n_q   <= 1'b1;
        txr_n_q  <= 1'b0;
        rxr_n_q  <= 1'b1;
      end else begin
        irq_q    <= (ier_q[0] && rx_trig) || (ier_q[1] && tx_empty);
        irq_oe_q <= mcr_q[DUBP_MCR_IRQ_BIT];
        gp_n_q   <= !mcr_q[DUBP_MCR_IRQ_BIT];
        txr_n_q  <= tx_full;
        rxr_n_q  <= rx_empty;
      end
    end

    always_comb begin
      rb = 8'h00;
      case (f_addr)
        DUBP_REG_DATA:     rb = rx_head[7:0];
        DUBP_REG_IRQ_EN:   rb = {6'h00, ier_q};
        DUBP_REG_FIFO_CTL: rb = {6'h00, ier_q[1] && tx_empty, ier_q[0] && rx_trig};
        DUBP_REG_MODEM:    rb = mcr_q;
        DUBP_REG_LINE: begin
          rb[DUBP_LSR_RX_DATA]                = !rx_empty;
          rb[DUBP_LSR_ERR_LSB +: DUBP_ERR_W]  = rx_empty ? 3'h0 : rx_head[RW-1 -: 3];
          rb[DUBP_LSR_TX_ROOM]                = !tx_full;
          rb[DUBP_LSR_TX_EMPTY]               = tx_empty;
        end
        DUBP_REG_RX_LVL:   rb = 8'(rx_cnt);
        DUBP_REG_SCRATCH:  rb = scr_q;
        default:           rb = 8'h00;
      endcase
    end

    assign rd_byte[c]  = rb;
    assign tx_valid[c] = txv_q;
    assign tx_data[c]  = txd_q;
  end

  // ==========================================================
  // pin mapping
  assign bus.chan_a_irq        = ch_g[0].irq_q;
  assign bus.chan_a_irq_oe     = ch_g[0].irq_oe_q;
  assign bus.chan_b_irq        = ch_g[1].irq_q;
  assign bus.chan_b_irq_oe     = ch_g[1].irq_oe_q;
  assign bus.chan_a_gp_out2_n  = ch_g[0].gp_n_q;
  assign bus.chan_b_gp_out2_n  = ch_g[1].gp_n_q;
  assign bus.chan_a_tx_ready_n = ch_g[0].txr_n_q;
  assign bus.chan_b_tx_ready_n = ch_g[1].txr_n_q;
  assign bus.chan_a_rx_ready_n = ch_g[0].rxr_n_q;
  assign bus.chan_b_rx_ready_n = ch_g[1].rxr_n_q;
endmodule : dubp_device
`default_nettype wire

/* dubp_host.sv */
`timescale 1ns/100ps
`default_nettype none
module dubp_host (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        srst,
  // device pins
  dubp_bus_if.host_mp      bus,
  // request
  input  wire logic        req_valid,
  input  wire logic        req_write,
  input  wire logic        req_chan,
  input  wire logic [2:0]  req_addr,
  input  wire logic [7:0]  req_wdata,
  output logic             req_ready,
  // answer
  output logic             rsp_valid,
  output logic [7:0]       rsp_rdata
);
  import dubp_pkg::*;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0001,
    ST_SETUP  = 4'b0010,
    ST_STROBE = 4'b0100,
    ST_HOLD   = 4'b1000
  } dubp_host_st_e;

  dubp_host_st_e st_q;
  logic [3:0]    cnt_q;
  logic          wr_q;
  logic          rd_n_q;
  logic          wr_n_q;
  logic          csa_n_q;
  logic          csb_n_q;
  logic [2:0]    addr_q;
  logic [7:0]    wdata_q;
  logic          oe_q;

  // ==========================================================
  // cycle sequencer
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_q      <= ST_IDLE;
      cnt_q     <= 4'h0;
      wr_q      <= 1'b0;
      rd_n_q    <= 1'b1;
      wr_n_q    <= 1'b1;
      csa_n_q   <= 1'b1;
      csb_n_q   <= 1'b1;
      addr_q    <= 3'h0;
      wdata_q   <= 8'h00;
      oe_q      <= 1'b0;
      req_ready <= 1'b1;
      rsp_valid <= 1'b0;
      rsp_rdata <= 8'h00;
    end else begin
      rsp_valid <= 1'b0;
      case (st_q)
        ST_IDLE: begin
          if (req_valid) begin
            st_q      <= ST_SETUP;
            cnt_q     <= 4'(DUBP_SETUP_CYC - 1);
            wr_q      <= req_write;
            csa_n_q   <= req_chan;
            csb_n_q   <= !req_chan;
            addr_q    <= req_addr;
            wdata_q   <= req_wdata;
            oe_q      <= req_write;
            req_ready <= 1'b0;
          end
        end
        ST_SETUP: begin
          if (cnt_q == 4'h0) begin
            st_q  <= ST_STROBE;
            cnt_q <= 4'(DUBP_STROBE_CYC - 1);
            rd_n_q <= wr_q;
            wr_n_q <= !wr_q;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        ST_STROBE: begin
          if (cnt_q == 4'h0) begin
            st_q   <= ST_HOLD;
            cnt_q  <= 4'(DUBP_HOLD_CYC - 1);
            rd_n_q <= 1'b1;
            wr_n_q <= 1'b1;
            if (!wr_q) begin
              rsp_rdata <= bus.bus_data;
            end
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        ST_HOLD: begin
          // data and select stay until the device has seen the rise
          if (cnt_q == 4'h0) begin
            st_q      <= ST_IDLE;
            csa_n_q   <= 1'b1;
            csb_n_q   <= 1'b1;
            oe_q      <= 1'b0;
            req_ready <= 1'b1;
            rsp_valid <= 1'b1;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  assign bus.read_strobe_n   = rd_n_q;
  assign bus.write_strobe_n  = wr_n_q;
  assign bus.chan_a_select_n = csa_n_q;
  assign bus.chan_b_select_n = csb_n_q;
  assign bus.reg_addr        = addr_q;
  assign bus.host_data       = wdata_q;
  assign bus.host_data_oe    = oe_q;
endmodule : dubp_host
`default_nettype wire

/* dubp_checker.sv */
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// pin-level checks on the link between host and device
module dubp_checker (
  // clock and reset
  input wire logic       sys_clk,
  input wire logic       srst,
  // strobes, selects, data
  input wire logic       read_strobe_n,
  input wire logic       write_strobe_n,
  input wire logic       chan_a_select_n,
  input wire logic       chan_b_select_n,
  input wire logic       host_data_oe,
  input wire logic       dev_data_oe,
  input wire logic [7:0] dev_data,
  // channel status pins
  input wire logic       chan_a_irq_oe,
  input wire logic       chan_b_irq_oe,
  input wire logic       chan_a_gp_out2_n,
  input wire logic       chan_b_gp_out2_n,
  input wire logic       chan_a_tx_ready_n,
  input wire logic       chan_b_rx_ready_n
);
  logic [7:0] strobe_age_q;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);

  // ==========================================================
  // cycles since any strobe was low; tx full and rx empty start only near a strobe
  always_ff @(posedge sys_clk) begin
    if (srst || !read_strobe_n || !write_strobe_n) begin
      strobe_age_q <= 8'h00;
    end else if (strobe_age_q != 8'hFF) begin
      strobe_age_q <= strobe_age_q + 8'h01;
    end
  end

  // ==========================================================
  // assertions
  bus_one_driver_a: assert property (!(host_data_oe && dev_data_oe))
    else $error("host and device drive the bus together");
  write_no_drive_a: assert property (!write_strobe_n |-> !dev_data_oe)
    else $error("device drives the bus during a write");
  read_cause_a: assert property ($rose(dev_data_oe) |->
    !read_strobe_n && !(chan_a_select_n && chan_b_select_n))
    else $error("bus driven without a selected read");
  read_hold_a: assert property (!read_strobe_n && dev_data_oe |=> dev_data_oe)
    else $error("read byte released before the strobe rose");
  read_stable_a: assert property (dev_data_oe && $past(dev_data_oe) && !read_strobe_n
    |-> $stable(dev_data))
    else $error("read byte changed while the strobe was low");
  gp_pair_a_a: assert property (chan_a_irq_oe == $past(chan_a_irq_oe)
    |-> chan_a_gp_out2_n == !chan_a_irq_oe)
    else $error("channel a gp output disagrees with irq enable");
  gp_pair_b_a: assert property (chan_b_irq_oe == $past(chan_b_irq_oe)
    |-> chan_b_gp_out2_n == !chan_b_irq_oe)
    else $error("channel b gp output disagrees with irq enable");
  tx_full_cause_a: assert property ($rose(chan_a_tx_ready_n) |-> strobe_age_q < 8'h0C)
    else $error("tx ready dropped with no host write");
  rx_empty_cause_a: assert property ($rose(chan_b_rx_ready_n) |-> strobe_age_q < 8'h0C)
    else $error("rx ready dropped with no host access");
endmodule : dubp_checker
`default_nettype wire

/* dubp_tb.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, s) begin checked++; if ((e) !== (s)) begin err_count++; \
  $display("mismatch %s expected %0h seen %0h", nm, e, s); end end
module dubp_tb;
  import dubp_pkg::*;
  logic            sys_clk, srst, req_valid, req_write, req_chan, req_ready, rsp_valid;
  logic [2:0]      req_addr;
  logic [7:0]      req_wdata, rsp_rdata, q, pins, exp_tx;
  logic [1:0]      tx_valid, tx_ready, rx_valid;
  logic [1:0][7:0] tx_data, rx_data;
  logic [1:0][2:0] rx_err;
  logic [7:0]      txq[2][$], rxq[$], regm[2][8];
  logic [2:0]      tagq[$];
  logic [31:0]     rnd;
  int              err_count, checked, cyc, n;

  dubp_bus_if i_dubp_bus_if ();
  dubp_device i_dubp_device (.sys_clk(sys_clk), .srst(srst), .bus(i_dubp_bus_if),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_err(rx_err));
  dubp_host i_dubp_host (.sys_clk(sys_clk), .srst(srst), .bus(i_dubp_bus_if),
    .req_valid(req_valid), .req_write(req_write), .req_chan(req_chan), .req_addr(req_addr),
    .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));
  dubp_checker i_dubp_checker (.sys_clk(sys_clk), .srst(srst),
    .read_strobe_n(i_dubp_bus_if.read_strobe_n), .write_strobe_n(i_dubp_bus_if.write_strobe_n),
    .chan_a_select_n(i_dubp_bus_if.chan_a_select_n),
    .chan_b_select_n(i_dubp_bus_if.chan_b_select_n),
    .host_data_oe(i_dubp_bus_if.host_data_oe), .dev_data_oe(i_dubp_bus_if.dev_data_oe),
    .dev_data(i_dubp_bus_if.dev_data), .chan_a_irq_oe(i_dubp_bus_if.chan_a_irq_oe),
    .chan_b_irq_oe(i_dubp_bus_if.chan_b_irq_oe),
    .chan_a_gp_out2_n(i_dubp_bus_if.chan_a_gp_out2_n),
    .chan_b_gp_out2_n(i_dubp_bus_if.chan_b_gp_out2_n),
    .chan_a_tx_ready_n(i_dubp_bus_if.chan_a_tx_ready_n),
    .chan_b_rx_ready_n(i_dubp_bus_if.chan_b_rx_ready_n));

  // gp a/b, irq_oe a/b, tx_ready_n a/b, rx_ready_n a/b
  assign pins = {i_dubp_bus_if.chan_a_gp_out2_n, i_dubp_bus_if.chan_b_gp_out2_n,
    i_dubp_bus_if.chan_a_irq_oe, i_dubp_bus_if.chan_b_irq_oe, i_dubp_bus_if.chan_a_tx_ready_n,
    i_dubp_bus_if.chan_b_tx_ready_n, i_dubp_bus_if.chan_a_rx_ready_n,
    i_dubp_bus_if.chan_b_rx_ready_n};

  // ==========================================================
  // clock, timeout, helpers
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      summarize();
    end
  end

  // serial side takes a byte on valid and ready
  always @(posedge sys_clk) begin
    for (int c = 0; c < 2; c++) begin
      if (!srst && tx_valid[c] === 1'b1 && tx_ready[c]) begin
        // pop once: the compare macro evaluates its arguments twice
        exp_tx = txq[c].size() ? txq[c].pop_front() : 8'hXX;
        `CHK("tx_data", exp_tx, tx_data[c])
      end
    end
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  task automatic xfer(input logic w, input logic ch, input logic [2:0] a, input logic [7:0] d);
    int k;
    // ready is looked at off the edge, so the take is seen exactly once
    @(negedge sys_clk);
    while (req_ready !== 1'b1) @(negedge sys_clk);
    req_valid = 1'b1;
    req_write = w;
    req_chan = ch;
    req_addr = a;
    req_wdata = d;
    @(negedge sys_clk);
    req_valid = 1'b0;
    k = 0;
    while (rsp_valid !== 1'b1 && k < 40) begin
      @(negedge sys_clk);
      k++;
    end
    if (k == 40) begin
      err_count++;
      $display("mismatch rsp_valid expected 1 seen %b", rsp_valid);
    end
    q = rsp_rdata;
  endtask : xfer

  task automatic rd(input logic ch, input logic [2:0] a, input logic [7:0] e);
    xfer(1'b0, ch, a, 8'h00);
    `CHK("read", e, q)
  endtask : rd

  task automatic push(input logic ch, input logic [7:0] d, input logic [2:0] e);
    @(negedge sys_clk);
    rx_valid[ch] = 1'b1;
    rx_data[ch] = d;
    rx_err[ch] = e;
    @(negedge sys_clk);
    rx_valid[ch] = 1'b0;
  endtask : push

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : summarize

  // ==========================================================
  // main sequence
  initial begin
    {srst, req_valid, req_write, req_chan, req_addr, req_wdata} = {1'b1, 14'h0000};
    {tx_ready, rx_valid, rx_data, rx_err} = '0;
    regm = '{default: 8'h00};
    rnd = 32'h58608097;
    repeat (20) @(negedge sys_clk);
    srst = 1'b0;
    `CHK("reset_pins", 8'hC3, pins)
    for (int c = 0; c < 2; c++) begin
      rnd = lfsr_next(rnd);
      regm[c][7] = rnd[7:0];
      xfer(1'b1, c[0], 3'h7, rnd[7:0]);
      xfer(1'b1, c[0], 3'h3, rnd[15:8]);
    end
    for (int c = 0; c < 2; c++) begin
      rd(c[0], 3'h7, regm[c][7]);
      rd(c[0], 3'h3, 8'h00);
      rd(c[0], 3'h5, 8'h60);
      xfer(1'b1, c[0], DUBP_REG_MODEM, 8'h08);
      `CHK("irq_pins", 8'hC3 ^ (c ? 8'h50 : 8'hA0), pins)
      rd(c[0], DUBP_REG_MODEM, 8'h08);
      xfer(1'b1, c[0], DUBP_REG_MODEM, 8'h00);
      `CHK("irq_pins", 8'hC3, pins)
    end
    $display("test registers done");
    // one byte sits in the output stage, so 17 fill it; the 18th is dropped
    for (int i = 0; i < 20; i++) begin
      rnd = lfsr_next(rnd);
      if (i > 17 || txq[0].size() < DUBP_FIFO_DEP + 1) txq[i > 17].push_back(rnd[7:0]);
      xfer(1'b1, i > 17, DUBP_REG_DATA, rnd[7:0]);
    end
    `CHK("tx_full", 1'b1, pins[3])
    rd(1'b0, DUBP_REG_LINE, 8'h00);
    n = 0;
    while ((txq[0].size() || txq[1].size()) && n < 3000) begin
      @(negedge sys_clk);
      rnd = lfsr_next(rnd);
      tx_ready = rnd[1:0];
      n++;
    end
    @(negedge sys_clk);
    tx_ready = 2'b00;
    `CHK("tx_left", 0, txq[0].size() + txq[1].size())
    `CHK("tx_room", 2'b00, pins[3:2])
    rd(1'b0, DUBP_REG_LINE, 8'h60);
    xfer(1'b1, 1'b1, DUBP_REG_IRQ_EN, 8'h02);
    rd(1'b1, DUBP_REG_FIFO_CTL, 8'h02);
    `CHK("irq_b", 1'b1, i_dubp_bus_if.chan_b_irq)
    // first byte waits in the output stage, second in the fifo until cleared
    for (int i = 0; i < 2; i++) begin
      rnd = lfsr_next(rnd);
      if (i == 0) txq[1].push_back(rnd[7:0]);
      xfer(1'b1, 1'b1, DUBP_REG_DATA, rnd[7:0]);
    end
    rd(1'b1, DUBP_REG_LINE, 8'h20);
    xfer(1'b1, 1'b1, DUBP_REG_FIFO_CTL, 8'h04);
    rd(1'b1, DUBP_REG_LINE, 8'h60);
    @(negedge sys_clk);
    tx_ready = 2'b10;
    @(negedge sys_clk);
    tx_ready = 2'b00;
    `CHK("tx_clear", 0, txq[1].size())
    $display("test transmit done");
    xfer(1'b1, 1'b0, DUBP_REG_MODEM, 8'h08);
    xfer(1'b1, 1'b0, DUBP_REG_IRQ_EN, 8'h01);
    for (int k = 0; k < 4; k++) begin
      xfer(1'b1, 1'b0, DUBP_REG_FIFO_CTL, {k[1:0], 6'h00});
      for (int i = 1; i < DUBP_TRIG_LVL[k]; i++) push(1'b0, 8'h00, 3'h0);
      repeat (4) @(negedge sys_clk);
      `CHK("irq_below", 1'b0, i_dubp_bus_if.chan_a_irq)
      push(1'b0, 8'h00, 3'h0);
      repeat (4) @(negedge sys_clk);
      `CHK("irq_level", 1'b1, i_dubp_bus_if.chan_a_irq)
      xfer(1'b1, 1'b0, DUBP_REG_FIFO_CTL, 8'h02);
      `CHK("irq_clear", 1'b0, i_dubp_bus_if.chan_a_irq)
    end
    xfer(1'b1, 1'b0, DUBP_REG_MODEM, 8'h00);
    $display("test triggers done");
    for (int i = 0; i < 3; i++) begin
      rnd = lfsr_next(rnd);
      rxq.push_back(rnd[7:0]);
      tagq.push_back(rnd[10:8]);
      push(1'b1, rnd[7:0], rnd[10:8]);
    end
    repeat (4) @(negedge sys_clk);
    `CHK("rx_ready", 1'b0, pins[0])
    rd(1'b1, DUBP_REG_RX_LVL, 8'h03);
    while (rxq.size()) begin
      rd(1'b1, DUBP_REG_LINE, {3'b011, 1'b0, tagq.pop_front(), 1'b1});
      rd(1'b1, DUBP_REG_DATA, rxq.pop_front());
    end
    `CHK("rx_empty", 1'b1, pins[0])
    $display("test receive done");
    summarize();
  end
endmodule : dubp_tb
`default_nettype wire
